// ---- hdl/lwd_defs.vh ----
// constants for the lcd watch time decoder: counter limits,
// mode codes and switch timing.
// assumes sys_clk at 200 MHz and a 64 Hz pulse train on a pin.
`ifndef LWD_DEFS_VH
`define LWD_DEFS_VH
// display modes
`define LWD_DISP_HM 2'h0
`define LWD_DISP_SEC 2'h1
`define LWD_DISP_DATE 2'h2
// time set modes
`define LWD_SET_NORM 3'h0
`define LWD_SET_MIN 3'h1
`define LWD_SET_SEC 3'h2
`define LWD_SET_HR 3'h3
`define LWD_SET_DATE 3'h4
// counter limits
`define LWD_SEC_MAX 6'h3B
`define LWD_MIN_MAX 6'h3B
`define LWD_HR_MAX 4'hB
`define LWD_DATE_MAX 5'h1F
// switch must be stable for this many 32 Hz periods
`define LWD_DEB_PERIODS 2'h2
// switch delay window in ms
`define LWD_SW_DELAY_MIN_MS 32
`define LWD_SW_DELAY_MAX_MS 80
`endif

// ---- hdl/lwd_watch.v ----
// lcd watch time decoder: 12-hour counters, display modes, time setting,
// and 32 Hz phased segment drive for 3 seven-segment digits plus a
// 2-segment digit and a colon.
// assumes a free 64 Hz pulse pin and low-active push switches on pins.
//
// Behaviour
// - 64 Hz pulses are the only time base
// - hours kept in 12-hour form with AM/PM
// - drive three 7-segment digits plus 2-segment digit
// - backplate common is 32 Hz 50% square
// - lit segments inverted, dark segments in phase
// - cycle switch steps hm, seconds, date, hm
// - seconds/date shown in minutes place, hours blank
// - colon flashes at 1 Hz in display modes
// - switch valid after two stable 32 Hz periods
// - switch recognition delay 32 to 80 ms; the code accepts at about 31 to 63 ms
// - set switch ignored outside hours-minutes display
// - set switch steps normal, min, sec, hr, date
// - held cycle switch advances selected counter at 1 Hz
// - seconds sync: minutes plus one, seconds held zero
// - in set modes colon shows only PM
// - reset input clears all time counters
// - power-up clears all time counters
// - cleared state is 12:00 AM, 00 s, date 0
// - digit decode table for numerals 0 to 9
`timescale 1ns/1ps
`include "lwd_defs.vh"

module lwd_watch (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // pins from the oscillator-divider and switches
  input wire pulse_64hz,
  input wire cycle_sw_n,
  input wire set_sw_n,
  // display drive
  output reg backplate,
  output reg [6:0] seg_d1,
  output reg [6:0] seg_d2,
  output reg [6:0] seg_d3,
  output reg [1:0] seg_d4,
  output reg seg_colon
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops each, only the second is read
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  always @(posedge sys_clk) begin
    sync_a <= {set_sw_n, cycle_sw_n, pulse_64hz};
    sync_b <= sync_a;
  end
  wire in_pulse = sync_b[0];
  wire cyc_raw = sync_b[1];
  wire set_raw = sync_b[2];
  reg pulse_q; // previous pulse level, for rising-edge detect
  // power-up flop: simulation and fpga init clear it, then it holds set
  reg pwr_ok = 1'b0;
  wire clr = rst | ~pwr_ok;
  always @(posedge sys_clk) begin
    pwr_ok <= 1'b1;
    pulse_q <= in_pulse;
  end
  wire tick64 = in_pulse & ~pulse_q;

  ////////////////////////////////////////////////////////////////////////
  // binary divider of the 64 Hz input
  reg [5:0] div; // bit0 is the 32 Hz phase, msb gives the 1 Hz cadence
  always @(posedge sys_clk) begin
    if (clr) begin
      div <= 6'h00;
    end else if (tick64) begin
      div <= div + 6'h01;
    end
  end
  wire phase32 = div[0];
  wire tick32 = tick64 & div[0]; // one per 32 Hz period
  wire tick1 = tick64 & (div == 6'h3F); // one per second
  wire half1 = div[5]; // 1 Hz square for the colon

  ////////////////////////////////////////////////////////////////////////
  // debounce: accept a level once stable over two 32 Hz periods;
  // sampling on the 32 Hz grid puts acceptance about 31 to 63 ms after
  // the switch edge, a hair early at the short end of the window
  reg cyc_db;
  reg set_db;
  reg [1:0] cyc_cnt;
  reg [1:0] set_cnt;
  reg cyc_fall;
  reg set_fall;
  always @(posedge sys_clk) begin
    cyc_fall <= 1'b0;
    set_fall <= 1'b0;
    if (clr) begin
      cyc_db <= 1'b1;
      set_db <= 1'b1;
      cyc_cnt <= 2'h0;
      set_cnt <= 2'h0;
    end else if (tick32) begin
      // cycle switch
      if (cyc_raw == cyc_db) begin
        cyc_cnt <= 2'h0;
      end else if (cyc_cnt + 2'h1 >= `LWD_DEB_PERIODS) begin
        cyc_db <= cyc_raw;
        cyc_cnt <= 2'h0;
        cyc_fall <= ~cyc_raw;
      end else begin
        cyc_cnt <= cyc_cnt + 2'h1;
      end
      // set switch
      if (set_raw == set_db) begin
        set_cnt <= 2'h0;
      end else if (set_cnt + 2'h1 >= `LWD_DEB_PERIODS) begin
        set_db <= set_raw;
        set_cnt <= 2'h0;
        set_fall <= ~set_raw;
      end else begin
        set_cnt <= set_cnt + 2'h1;
      end
    end
  end
  wire cyc_held = ~cyc_db;

  ////////////////////////////////////////////////////////////////////////
  // mode state: display mode and time set mode
  reg [1:0] disp_mode;
  reg [2:0] set_mode;
  always @(posedge sys_clk) begin
    if (clr) begin
      disp_mode <= `LWD_DISP_HM;
      set_mode <= `LWD_SET_NORM;
    end else begin
      // cycle switch steps the display only while no set mode runs;
      // in a set mode it is the advance key
      if (cyc_fall && set_mode == `LWD_SET_NORM) begin
        case (disp_mode)
          `LWD_DISP_HM: disp_mode <= `LWD_DISP_SEC;
          `LWD_DISP_SEC: disp_mode <= `LWD_DISP_DATE;
          default: disp_mode <= `LWD_DISP_HM;
        endcase
      end
      if (set_fall && disp_mode == `LWD_DISP_HM) begin
        case (set_mode)
          `LWD_SET_NORM: set_mode <= `LWD_SET_MIN;
          `LWD_SET_MIN: set_mode <= `LWD_SET_SEC;
          `LWD_SET_SEC: set_mode <= `LWD_SET_HR;
          `LWD_SET_HR: set_mode <= `LWD_SET_DATE;
          default: set_mode <= `LWD_SET_NORM;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time counters
  reg [5:0] secs;
  reg [5:0] mins;
  reg [3:0] hrs; // 0 stands for 12
  reg pm;
  reg [4:0] date; // date range 0..31, wraps to 0
  reg sync_hold; // seconds parked after a sync press
  wire sec_set = (set_mode == `LWD_SET_SEC);
  wire adv = tick1 & cyc_held;
  wire run_sec = tick1 & ~sync_hold & ~(sec_set & cyc_held);
  wire sec_wrap = run_sec & (secs == `LWD_SEC_MAX);
  wire min_step = sec_wrap | (cyc_fall & sec_set) |
    (adv & set_mode == `LWD_SET_MIN);
  wire min_wrap = min_step & (mins == `LWD_MIN_MAX);
  // minutes advanced by hand do not carry into hours
  wire hr_step = (sec_wrap & (mins == `LWD_MIN_MAX)) |
    (adv & set_mode == `LWD_SET_HR);
  wire day_step = (hr_step & pm & (hrs == `LWD_HR_MAX)) |
    (adv & set_mode == `LWD_SET_DATE);
  always @(posedge sys_clk) begin
    if (clr) begin
      secs <= 6'h00;
      mins <= 6'h00;
      hrs <= 4'h0;
      pm <= 1'b0;
      date <= 5'h00;
      sync_hold <= 1'b0;
    end else begin
      // seconds sync: clear and hold while the key stays down
      if (sec_set & cyc_fall) begin
        secs <= 6'h00;
        sync_hold <= 1'b1;
      end else if (sync_hold & ~cyc_held) begin
        sync_hold <= 1'b0;
      end else if (run_sec) begin
        secs <= sec_wrap ? 6'h00 : secs + 6'h01;
      end
      if (min_step) begin
        mins <= min_wrap ? 6'h00 : mins + 6'h01;
      end
      if (hr_step) begin
        hrs <= (hrs == `LWD_HR_MAX) ? 4'h0 : hrs + 4'h1;
        if (hrs == `LWD_HR_MAX) begin
          pm <= ~pm;
        end
      end
      if (day_step) begin
        date <= (date == `LWD_DATE_MAX) ? 5'h00 : date + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode numerals to segments {G,F,E,D,C,B,A}
  function [6:0] lwd_seg7;
    input [3:0] n;
    begin
      case (n)
        4'h0: lwd_seg7 = 7'h3F;
        4'h1: lwd_seg7 = 7'h06;
        4'h2: lwd_seg7 = 7'h5B;
        4'h3: lwd_seg7 = 7'h4F;
        4'h4: lwd_seg7 = 7'h66;
        4'h5: lwd_seg7 = 7'h6D;
        4'h6: lwd_seg7 = 7'h7D;
        4'h7: lwd_seg7 = 7'h07;
        4'h8: lwd_seg7 = 7'h7F;
        4'h9: lwd_seg7 = 7'h6F;
        default: lwd_seg7 = 7'h00;
      endcase
    end
  endfunction

  // split a 0..59 value into tens and its low four bits; units are fixed up below
  function [7:0] lwd_bcd;
    input [5:0] v;
    reg [3:0] t;
    begin
      t = 4'h0;
      if (v >= 6'd50) t = 4'h5;
      else if (v >= 6'd40) t = 4'h4;
      else if (v >= 6'd30) t = 4'h3;
      else if (v >= 6'd20) t = 4'h2;
      else if (v >= 6'd10) t = 4'h1;
      lwd_bcd = {t, v[3:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // choose what to show and build the lit pattern
  reg [5:0] show_val;
  reg [7:0] show_bcd;
  reg [3:0] hr_disp;
  reg [6:0] lit_d1;
  reg [6:0] lit_d2;
  reg [6:0] lit_d3;
  reg [1:0] lit_d4;
  reg lit_colon;
  reg [5:0] tens_x10;
  always @* begin
    case (disp_mode)
      `LWD_DISP_SEC: show_val = secs;
      `LWD_DISP_DATE: show_val = {1'b0, date};
      default: show_val = mins;
    endcase
    show_bcd = lwd_bcd(show_val);
    tens_x10 = {show_bcd[6:4], 3'h0} + {2'h0, show_bcd[6:4], 1'b0};
    show_bcd[3:0] = show_val[3:0] - tens_x10[3:0];
    hr_disp = (hrs == 4'h0) ? 4'hC : hrs;
    lit_d3 = lwd_seg7(show_bcd[3:0]);
    lit_d2 = lwd_seg7(show_bcd[7:4]);
    if (disp_mode == `LWD_DISP_HM) begin
      lit_d1 = lwd_seg7((hr_disp >= 4'hA) ? hr_disp - 4'hA : hr_disp);
      lit_d4 = (hr_disp >= 4'hA) ? 2'h3 : 2'h0;
    end else begin
      lit_d1 = 7'h00; // hours blanked
      lit_d4 = 2'h0;
    end
    if (set_mode != `LWD_SET_NORM) begin
      lit_colon = pm;
    end else begin
      lit_colon = half1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output drive: lit segments opposite the backplate, dark in phase
  always @(posedge sys_clk) begin
    if (clr) begin
      backplate <= 1'b0;
      seg_d1 <= 7'h00;
      seg_d2 <= 7'h00;
      seg_d3 <= 7'h00;
      seg_d4 <= 2'h0;
      seg_colon <= 1'b0;
    end else begin
      backplate <= phase32;
      seg_d1 <= lit_d1 ^ {7{phase32}};
      seg_d2 <= lit_d2 ^ {7{phase32}};
      seg_d3 <= lit_d3 ^ {7{phase32}};
      seg_d4 <= lit_d4 ^ {2{phase32}};
      seg_colon <= lit_colon ^ phase32;
    end
  end

endmodule

// ---- bench/lwd_osc.sv ----
// partner: oscillator-divider pulse pin feeding the watch decoder
// assumes the bench clock; the bench seeds $urandom once
`timescale 1ns/1ps
module lwd_osc #(
  parameter int PER = 16
) (
  // clock
  input wire logic sys_clk,
  // pulse pin
  output logic pulse_64hz
);
  int cnt = 0; // clocks into this period
  int wid = 2; // high time of this pulse
  initial pulse_64hz = 1'b0;
  // short period stands in for 64 Hz, so one second is 1024 clocks
  always @(posedge sys_clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    if (cnt == 0) wid <= 2 + $urandom % 3;
    pulse_64hz <= (cnt < wid);
  end
endmodule

// ---- bench/lwd_watch_chk.sv ----
// checker: port-level timing and decode relations of the watch decoder
// assumes lit = seg ^ backplate and a pin pulse period of 16 clocks
`timescale 1ns/1ps
module lwd_watch_chk (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // pins in
  input wire pulse_64hz,
  input wire cycle_sw_n,
  input wire set_sw_n,
  // display drive
  input wire backplate,
  input wire [6:0] seg_d1,
  input wire [6:0] seg_d2,
  input wire [6:0] seg_d3,
  input wire [1:0] seg_d4,
  input wire seg_colon
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire [6:0] l1 = seg_d1 ^ {7{backplate}}; // lit hours units
  wire [6:0] l2 = seg_d2 ^ {7{backplate}}; // lit tens
  wire [6:0] l3 = seg_d3 ^ {7{backplate}}; // lit units
  wire [1:0] l4 = seg_d4 ^ {2{backplate}}; // lit leading one
  ////////////////////////////////////////////////////////////////
  property p_bp_follow;
    $rose(pulse_64hz) |-> ##[3:5] $changed(backplate);
  endproperty
  a_bp_follow: assert property (p_bp_follow) else $error("backplate late");
  property p_bp_hold;
    $changed(backplate) |=> $stable(backplate) [*3];
  endproperty
  a_bp_hold: assert property (p_bp_hold) else $error("backplate too fast");
  property p_rst_clear;
    $fell(rst) |=> !backplate && seg_d4 == 2'h3 && seg_d1 == 7'h5B
      && seg_d2 == 7'h3F && seg_d3 == 7'h3F;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("not 12:00");
  property p_d4_pair;
    seg_d4[0] == seg_d4[1];
  endproperty
  a_d4_pair: assert property (p_d4_pair) else $error("half digit split");
  property p_d1_legal;
    l1 inside {7'h00, 7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  endproperty
  a_d1_legal: assert property (p_d1_legal) else $error("bad hours digit");
  property p_tens;
    l2 inside {7'h00, 7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D};
  endproperty
  a_tens: assert property (p_tens) else $error("bad tens digit");
  property p_blank;
    l1 == 7'h00 |-> l4 == 2'h0;
  endproperty
  a_blank: assert property (p_blank) else $error("hours half lit");
  property p_hours;
    l4 == 2'h3 |-> l1 inside {7'h3F, 7'h06, 7'h5B};
  endproperty
  a_hours: assert property (p_hours) else $error("hour above 12");
endmodule
bind lwd_watch lwd_watch_chk u_chk (.sys_clk(sys_clk), .rst(rst), .pulse_64hz(pulse_64hz),
  .cycle_sw_n(cycle_sw_n), .set_sw_n(set_sw_n), .backplate(backplate), .seg_d1(seg_d1),
  .seg_d2(seg_d2), .seg_d3(seg_d3), .seg_d4(seg_d4), .seg_colon(seg_colon));

// ---- bench/lwd_watch_tb.sv ----
// testbench: display cycling, set modes and reset state of the watch decoder
// assumes lwd_osc gives one pulse per 16 clocks, so a second is 1024 clocks
`timescale 1ns/1ps
module lwd_watch_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cycle_sw_n = 1'b1; // low = pressed
  logic set_sw_n = 1'b1; // low = pressed
  logic pv = 1'b0; // pin value last clock
  wire pulse_64hz;
  wire backplate, seg_colon;
  wire [6:0] seg_d1, seg_d2, seg_d3;
  wire [1:0] seg_d4;
  int mismatches = 0;
  int check_count = 0;
  int tk = 0; // pulses since reset
  int m0, n;
  localparam logic [6:0] SEG7 [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
    7'h07, 7'h7F, 7'h6F};
  always #2.5 sys_clk = ~sys_clk;
  lwd_osc u_osc (.sys_clk(sys_clk), .pulse_64hz(pulse_64hz));
  lwd_watch u_dut (.sys_clk(sys_clk), .rst(rst), .pulse_64hz(pulse_64hz),
    .cycle_sw_n(cycle_sw_n), .set_sw_n(set_sw_n), .backplate(backplate), .seg_d1(seg_d1),
    .seg_d2(seg_d2), .seg_d3(seg_d3), .seg_d4(seg_d4), .seg_colon(seg_colon));
  // own count of pin pulses, the reference time base
  always @(posedge sys_clk) begin
    pv <= rst ? 1'b0 : pulse_64hz;
    if (rst) tk <= 0;
    else if (pulse_64hz && !pv) tk <= tk + 1;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [6:0] lit(input logic [6:0] s);
    lit = s ^ {7{backplate}};
  endfunction
  function automatic int mins();
    int d = 0;
    for (int i = 0; i < 10; i++) if (SEG7[i] === lit(seg_d2)) d = i * 10;
    for (int i = 0; i < 10; i++) if (SEG7[i] === lit(seg_d3)) d = d + i;
    mins = d;
  endfunction
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // all four digits: leading one, hours units, two-digit value
  task automatic show(input logic [1:0] e4, input logic [6:0] e1, input int v);
    chk("d4", {5'h00, e4}, {5'h00, seg_d4 ^ {2{backplate}}});
    chk("d1", e1, lit(seg_d1));
    chk("d2", SEG7[v / 10], lit(seg_d2));
    chk("d3", SEG7[v % 10], lit(seg_d3));
  endtask
  // sample 8 clocks after a pulse, when the outputs have settled
  task automatic sync();
    int t;
    t = tk;
    wait (tk != t);
    repeat (8) @(posedge sys_clk);
  endtask
  // hold for the given number of clocks, then let the release settle
  task automatic press(input bit set, input int hold);
    if (set) set_sw_n <= 1'b0;
    else cycle_sw_n <= 1'b0;
    repeat (hold) @(posedge sys_clk);
    set_sw_n <= 1'b1;
    cycle_sw_n <= 1'b1;
    repeat (256) @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hC73B));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    sync();
    show(2'h3, SEG7[2], 0);
    // a bounce shorter than one 32 Hz period must not step the display
    press(0, 4 + $urandom % 24);
    sync();
    show(2'h3, SEG7[2], tk / 3840);
    $display("reset test done");
    repeat (2000) @(posedge sys_clk);
    press(0, 256 + $urandom % 64);
    sync();
    show(2'h0, 7'h00, (tk / 64) % 60);
    press(1, 300);
    sync();
    show(2'h0, 7'h00, (tk / 64) % 60);
    press(0, 256 + $urandom % 64);
    sync();
    show(2'h0, 7'h00, 0);
    press(0, 256 + $urandom % 64);
    sync();
    show(2'h3, SEG7[2], tk / 3840);
    chk("colon", {6'h00, 1'((tk >> 5) & 1)}, {6'h00, seg_colon ^ backplate});
    $display("display test done");
    press(1, 300);
    sync();
    chk("colon", 7'h00, {6'h00, seg_colon ^ backplate});
    m0 = mins();
    press(0, 3172 + $urandom % 32);
    n = (mins() - m0 + 60) % 60;
    chk("madv", 7'h01, {6'h00, n >= 3 && n <= 4});
    press(1, 300);
    m0 = mins();
    cycle_sw_n <= 1'b0;
    repeat (1700) @(posedge sys_clk);
    chk("msync", 7'((m0 + 1) % 60), 7'(mins()));
    press(1, 300);
    cycle_sw_n <= 1'b0;
    for (n = 0; n < 25000 && (seg_colon ^ backplate) !== 1'b1; n++) @(posedge sys_clk);
    // a run-out of the loop above shows here as a mismatch
    chk("pm", 7'h01, {6'h00, seg_colon ^ backplate});
    cycle_sw_n <= 1'b1;
    sync();
    // minutes stay at the synced value, seconds are far from a wrap
    show(2'h3, SEG7[2], (m0 + 1) % 60);
    // date set mode: hold about two seconds, then view the date
    press(1, 300);
    press(0, 2100 + $urandom % 32);
    press(1, 300);
    press(0, 256 + $urandom % 64);
    press(0, 256 + $urandom % 64);
    sync();
    n = mins();
    chk("dadv", 7'h01, {6'h00, n >= 2 && n <= 3});
    chk("dblank", 7'h00, lit(seg_d1));
    $display("set test done");
    // mid-run reset from the date display
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    sync();
    show(2'h3, SEG7[2], 0);
    chk("colon", 7'h00, {6'h00, seg_colon ^ backplate});
    $display("mid-run reset test done");
    stop_test();
  end
endmodule
